// ### dv/tmx_src.sv
`timescale 1ns/1ns
// Outside clock and clear sources, levels that hold between flips
module tmx_src (
    // Clock
    input wire logic mclk,
    // Pin levels, bit 0 feeds timer one
    output logic [3:0] clk_pin,
    output logic [3:0] clr_pin
);
    initial begin
        clk_pin = 4'h0;
        clr_pin = 4'h0;
    end
    // Flip one pin after an edge, then give sync and count time
    task automatic flip(input bit clr, input int i);
        @(posedge mclk);
        if (clr) clr_pin[i] <= ~clr_pin[i];
        else clk_pin[i] <= ~clk_pin[i];
        repeat (6) @(posedge mclk);
    endtask : flip
endmodule : tmx_src

// ### dv/tmx_top_test.sv
`timescale 1ns/1ns
module tmx_top_test;
    import tmx_pkg::*;
    logic mclk, sys_rst, baud_int_tick, baud_tick, reg_wr, reg_rd;
    logic [3:0] reg_addr, cp, rp;
    logic [15:0] reg_wdata, reg_rdata;
    int failures, n_checks, n_baud;
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    tmx_src src (.mclk(mclk), .clk_pin(cp), .clr_pin(rp));
    tmx_top uut (.mclk(mclk), .sys_rst(sys_rst),
        .timer_one_ext_clock(cp[0]), .timer_two_ext_clock(cp[1]),
        .timer_three_ext_clock(cp[2]), .timer_four_ext_clock(cp[3]),
        .timer_one_ext_clear(rp[0]), .timer_two_ext_clear(rp[1]),
        .timer_three_ext_clear(rp[2]), .timer_four_ext_clear(rp[3]),
        .baud_int_tick(baud_int_tick), .baud_tick(baud_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Pulses seen on the baud output
    always @(posedge mclk) if (baud_tick === 1'b1) n_baud <= n_baud + 1;
    task automatic stop_test;
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle write, then an idle edge so the strobe never re-rises at once
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge mclk);
    endtask : rd
    // Rise, fall and both edge modes on each timer, one full pulse per mode
    task automatic t_edges;
        for (int t = 0; t < 4; t++) begin
            for (int e = 1; e < 4; e++) begin
                wr(4'(4 + t), 16'h0000);
                wr(4'(t), 16'((e << 2) | 1));
                src.flip(0, t);
                src.flip(0, t);
                rd(4'(4 + t), (e == 3) ? 16'h0002 : 16'h0001);
            end
        end
        wr(4'h4, 16'h0000);
        wr(4'h0, 16'h0007);
        src.flip(0, 0);
        src.flip(0, 0);
        rd(4'h4, 16'hffff);
    endtask : t_edges
    // Clear on rise, fall and both edge modes, a rise then a fall
    task automatic t_clear;
        for (int t = 0; t < 4; t++) begin
            for (int e = 1; e < 4; e++) begin
                wr(4'(t), 16'((e << 4) | 1));
                wr(4'(4 + t), 16'h0005);
                src.flip(1, t);
                rd(4'(4 + t), (e == 2) ? 16'h0005 : 16'h0000);
                wr(4'(4 + t), 16'h0005);
                src.flip(1, t);
                rd(4'(4 + t), (e == 1) ? 16'h0005 : 16'h0000);
            end
        end
    endtask : t_clear
    // Baud source swaps from timer two pin to internal tick
    task automatic t_baud;
        int base;
        baud_int_tick <= 1'b1;
        wr(4'h1, 16'h0005);
        wr(TMX_BAUD_OFS, 16'h0001);
        base = n_baud;
        src.flip(0, 1);
        src.flip(0, 1);
        chk(16'(n_baud - base), 16'h0001);
        wr(TMX_BAUD_OFS, 16'h0000);
        @(posedge mclk);
        #1 chk(16'(baud_tick), 16'h0001);
        @(posedge mclk);
        baud_int_tick <= 1'b0;
        #1 chk(16'(baud_tick), 16'h0000);
    endtask : t_baud
    // Mid-run reset: counts drop to zero, a pin parked high is no edge
    task automatic t_reset;
        wr(4'h5, 16'h1234);
        wr(4'h0, 16'h0005);
        src.flip(0, 0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        wr(4'h0, 16'h0005);
        repeat (4) @(posedge mclk);
        rd(4'h4, 16'h0000);
        rd(4'h5, 16'h0000);
        src.flip(0, 0);
        src.flip(0, 0);
        rd(4'h4, 16'h0001);
    endtask : t_reset
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        baud_int_tick = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 9; a++) rd(4'(a), 16'h0000);
        t_edges;
        t_clear;
        t_reset;
        t_baud;
        stop_test;
    end
endmodule : tmx_top_test

// ### verilog/tmx_edge.sv
`timescale 1ns/1ns
// Two-flop synchroniser plus edge picker for one pin
module tmx_edge (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pin and selection
    input wire logic pin,
    input wire logic [1:0] sel,
    // Qualified edge pulse
    output logic hit
);
    import tmx_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [2:0] warm;
    } tmx_edge_st_t;
    tmx_edge_st_t st;
    tmx_edge_st_t next_st;
    logic rise;
    logic fall;

    // s1 only feeds s2; s3 holds the prior synced level
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Fills with ones after reset; s3 is a real sample once full
        next_st.warm = {st.warm[1:0], 1'b1};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Edge choice from synchronised levels only
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
    // Blind until warm, so a pin parked high over reset is no rise
    assign hit = st.warm[2] & ((sel[0] & rise) | (sel[1] & fall));
endmodule : tmx_edge

// ### verilog/tmx_pkg.sv
package tmx_pkg;
    // Register map, word offsets on the plain port
    localparam logic [3:0] TMX_CTRL_OFS = 4'h0;
    localparam logic [3:0] TMX_BAUD_OFS = 4'h8;
    localparam logic [3:0] TMX_CNT_OFS = 4'h4;
    // Per-timer control field positions
    localparam int TMX_EN_BIT = 0;
    localparam int TMX_DIR_BIT = 1;
    localparam int TMX_CEDGE_LSB = 2;
    localparam int TMX_REDGE_LSB = 4;
    localparam int TMX_CTRL_BITS = 8;
    localparam logic [15:0] TMX_CNT_RST = 16'h0000;
    localparam logic [7:0] TMX_CTRL_RST = 8'h00;
    localparam int TMX_SYNC_STAGES = 2;
    // Edge select encoding
    typedef enum logic [1:0] {
        TMX_EDGE_OFF = 2'h0,
        TMX_EDGE_RISE = 2'h1,
        TMX_EDGE_FALL = 2'h2,
        TMX_EDGE_BOTH = 2'h3
    } tmx_edge_t;
endpackage : tmx_pkg

// ### verilog/tmx_top.sv
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
// Notes on behaviour
// RL1: Each timer steps up or down on chosen external clock edges.
// RL2: Each timer clears on chosen external clear input edges.
// RL3: Timer two clock pin can drive baud generator instead of internal clock.
// RL4: Clock inputs come from shared port 7 lines 0,2,4,6.
// RL5: Clear inputs come from shared port 7 odd lines.
// RL6: Pins synchronised before edge detection; clear edge loads zero.
module tmx_top #(
    parameter int NTIM = 4,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // External clock pins
    input wire logic timer_one_ext_clock,
    input wire logic timer_two_ext_clock,
    input wire logic timer_three_ext_clock,
    input wire logic timer_four_ext_clock,
    // External clear pins
    input wire logic timer_one_ext_clear,
    input wire logic timer_two_ext_clear,
    input wire logic timer_three_ext_clear,
    input wire logic timer_four_ext_clear,
    // Baud generator source
    input wire logic baud_int_tick,
    output logic baud_tick,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    import tmx_pkg::*;

    // All state in one record; next_st is its combinational copy
    typedef struct packed {
        logic [NTIM-1:0][7:0] ctrl;
        logic [NTIM-1:0][CW-1:0] cnt;
        logic baud_ext;
        logic [15:0] rdata;
    } tmx_st_t;
    tmx_st_t st;
    tmx_st_t next_st;

    // Pin levels per timer and their qualified edge pulses
    logic [NTIM-1:0] clk_pin;
    logic [NTIM-1:0] clr_pin;
    logic [NTIM-1:0] clk_hit;
    logic [NTIM-1:0] clr_hit;

    // Pin map to port 7 lines: even lines clock, odd lines clear
    assign clk_pin = {timer_four_ext_clock, timer_three_ext_clock,
                      timer_two_ext_clock, timer_one_ext_clock}; // [RL4]
    assign clr_pin = {timer_four_ext_clear, timer_three_ext_clear,
                      timer_two_ext_clear, timer_one_ext_clear}; // [RL5]

    // One synchroniser and edge picker per pin
    genvar gi;
    generate
        for (gi = 0; gi < NTIM; gi++) begin : g_pin
            tmx_edge u_clk (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .pin(clk_pin[gi]),
                .sel(st.ctrl[gi][TMX_CEDGE_LSB +: 2]),
                .hit(clk_hit[gi])
            ); // [RL6]
            tmx_edge u_clr (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .pin(clr_pin[gi]),
                .sel(st.ctrl[gi][TMX_REDGE_LSB +: 2]),
                .hit(clr_hit[gi])
            ); // [RL6]
        end
    endgenerate

    // Count, clear and register access; clear beats count, bus write last
    always_comb begin
        next_st = st;
        next_st.rdata = 16'h0000;
        // Pin events first: a clear edge swallows a step in that cycle
        for (int i = 0; i < NTIM; i++) begin
            if (clr_hit[i]) begin
                next_st.cnt[i] = TMX_CNT_RST[CW-1:0]; // [RL2] [RL6]
            end else if (st.ctrl[i][TMX_EN_BIT] && clk_hit[i]) begin
                if (st.ctrl[i][TMX_DIR_BIT]) begin
                    next_st.cnt[i] = st.cnt[i] - 1'b1; // [RL1]
                end else begin
                    next_st.cnt[i] = st.cnt[i] + 1'b1; // [RL1]
                end
            end
        end
        // Bus writes last, so software always has the final word
        if (reg_wr) begin
            if (reg_addr == TMX_BAUD_OFS) begin
                next_st.baud_ext = reg_wdata[0];
            end
            for (int i = 0; i < NTIM; i++) begin
                if (reg_addr == TMX_CTRL_OFS + 4'(i)) begin
                    next_st.ctrl[i] = reg_wdata[7:0];
                end
                if (reg_addr == TMX_CNT_OFS + 4'(i)) begin
                    next_st.cnt[i] = reg_wdata[CW-1:0];
                end
            end
        end
        // Read data for the next cycle only; holes read as zero
        if (reg_rd) begin
            if (reg_addr == TMX_BAUD_OFS) begin
                next_st.rdata = {15'h0000, st.baud_ext};
            end
            for (int i = 0; i < NTIM; i++) begin
                if (reg_addr == TMX_CTRL_OFS + 4'(i)) begin
                    next_st.rdata = {8'h00, st.ctrl[i]};
                end
                if (reg_addr == TMX_CNT_OFS + 4'(i)) begin
                    next_st.rdata = 16'(st.cnt[i]);
                end
            end
        end
    end

    // State register; sync reset puts every field at its reset value
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NTIM; i++) begin
                st.ctrl[i] <= TMX_CTRL_RST;
                st.cnt[i] <= TMX_CNT_RST[CW-1:0];
            end
            st.baud_ext <= 1'b0;
            st.rdata <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    // Baud source: timer two clock edge or internal tick
    assign baud_tick = st.baud_ext ? clk_hit[1] : baud_int_tick; // [RL3]
    assign reg_rdata = st.rdata;

    // Checks on counting, clearing and the baud path
    property p_clear;
        @(posedge mclk) disable iff (sys_rst)
        (clr_hit[0] && !(reg_wr && reg_addr == TMX_CNT_OFS))
            |=> st.cnt[0] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed"); // [RL2]

    property p_up;
        @(posedge mclk) disable iff (sys_rst)
        (clk_hit[2] && !clr_hit[2] && st.ctrl[2][TMX_EN_BIT]
            && !st.ctrl[2][TMX_DIR_BIT] && !reg_wr)
            |=> st.cnt[2] == $past(st.cnt[2]) + 1'b1;
    endproperty
    a_up: assert property (p_up) else $error("count up wrong"); // [RL1]

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        (!clk_hit[3] && !clr_hit[3] && !reg_wr) |=> $stable(st.cnt[3]);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved"); // [RL1]

    property p_baud;
        @(posedge mclk) disable iff (sys_rst)
        st.baud_ext |-> baud_tick == clk_hit[1];
    endproperty
    a_baud: assert property (p_baud) else $error("baud source"); // [RL3]

    property p_baud_pin;
        @(posedge mclk) disable iff (sys_rst)
        (st.baud_ext && baud_tick) |->
            $past(timer_two_ext_clock, 2) != $past(timer_two_ext_clock, 3);
    endproperty
    a_baud_pin: assert property (p_baud_pin) else $error("baud pin"); // [RL3]

    property p_down;
        @(posedge mclk) disable iff (sys_rst)
        (clk_hit[0] && !clr_hit[0] && st.ctrl[0][TMX_EN_BIT]
            && st.ctrl[0][TMX_DIR_BIT] && !reg_wr)
            |=> st.cnt[0] == $past(st.cnt[0]) - 1'b1;
    endproperty
    a_down: assert property (p_down) else $error("count down wrong"); // [RL1]

    property p_up_one;
        @(posedge mclk) disable iff (sys_rst)
        (clk_hit[0] && !clr_hit[0] && st.ctrl[0][TMX_EN_BIT]
            && !st.ctrl[0][TMX_DIR_BIT] && !reg_wr)
            |=> st.cnt[0] == $past(st.cnt[0]) + 1'b1;
    endproperty
    a_up_one: assert property (p_up_one) else $error("step up wrong"); // [RL1]

    // Per-timer checks on the pin path and on counts
    for (gi = 0; gi < NTIM; gi++) begin : g_chk
        // A clear edge with no write to that count leaves zero
        property p_clear_each;
            @(posedge mclk) disable iff (sys_rst)
            (clr_hit[gi] && !(reg_wr && reg_addr == TMX_CNT_OFS + 4'(gi)))
                |=> st.cnt[gi] == '0;
        endproperty
        a_clear_each: assert property (p_clear_each) // [RL2]
            else $error("clear lost");

        // No pin event and no write: the count must not move
        property p_hold_each;
            @(posedge mclk) disable iff (sys_rst)
            (!clk_hit[gi] && !clr_hit[gi] && !reg_wr)
                |=> $stable(st.cnt[gi]);
        endproperty
        a_hold_each: assert property (p_hold_each) // [RL1]
            else $error("count drift");

        // Edges show two syncs late, never straight from the pin
        property p_clk_sync;
            @(posedge mclk) disable iff (sys_rst)
            clk_hit[gi] |-> $past(clk_pin[gi], 2) != $past(clk_pin[gi], 3);
        endproperty
        a_clk_sync: assert property (p_clk_sync) // [RL6]
            else $error("clock edge timing");

        property p_clr_sync;
            @(posedge mclk) disable iff (sys_rst)
            clr_hit[gi] |-> $past(clr_pin[gi], 2) != $past(clr_pin[gi], 3);
        endproperty
        a_clr_sync: assert property (p_clr_sync) // [RL6]
            else $error("clear edge timing");
    end
endmodule : tmx_top
